// *** design/timer_ctrl_params.svh ***
/*
  Constants for the timer enable and pin A output-level control bits.
  Assumes inclusion by bare name from the package and the control module.
*/
// Function
// - In waveform output use, the level bit equals pin A's driven level.
// - Hardware sets and clears the level bit as it toggles pin A.
// - A software level write beats a same-cycle hardware toggle.
// - The level bit does not reach the pin when input or disabled.
// - The unit-enable bit is the master switch: 1 runs, 0 disables.
// - While disabled, counter clocks stop so nothing counts.
// - While disabled, software writes to counters, capture/reload, pending are ignored.
// - While disabled, pin A is released from drive and becomes an input.
`ifndef TIMER_CTRL_PARAMS_SVH
`define TIMER_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define UNIT_ENABLE_RESET 1'h0
`define OUTPUT_LEVEL_RESET 1'h0
`define LEVEL_LOW 1'h0
`define LEVEL_HIGH 1'h1
`define SYNC_STAGES 2

`endif

// *** design/timer_ctrl_pkg.sv ***
/*
  Types shared by the timer control block.
  Assumes timer_ctrl_params.svh is on the include path.
*/
`include "timer_ctrl_params.svh"

package timer_ctrl_pkg;

  // --------------------------------------------------------------------
  // Write strobes towards the counter unit
  // --------------------------------------------------------------------
  typedef struct packed {
    logic counterOne;
    logic counterTwo;
    logic captureReloadA;
    logic captureReloadB;
    logic pendingFlags;
  } unit_write_t;

  // --------------------------------------------------------------------
  // Software access to the two control bits
  // --------------------------------------------------------------------
  typedef struct packed {
    logic enableWrite;
    logic enableData;
    logic levelWrite;
    logic levelData;
  } ctrl_write_t;

endpackage

// *** design/bit_synchronizer.sv ***
/*
  Two-stage synchroniser for one asynchronous level.
  Assumes the caller supplies the clock enable and a synchronous-domain reset.
*/
`timescale 1ns/100ps
`default_nettype none

module bit_synchronizer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic async,
  output logic synced
);

  logic firstStage;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      firstStage <= 1'h0;
      synced <= 1'h0;
    end else if (clkEn) begin
      firstStage <= async;
      synced <= firstStage;
    end
  end

endmodule

`default_nettype wire

// *** design/timer_ctrl.sv ***
/*
  Unit enable and pin A output-level control of a multifunction timer.
  Assumes the mode logic outside says whether pin A is a waveform output,
  and the waveform generator raises hwToggle for one cycle per pin toggle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctrl_params.svh"

module timer_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire timer_ctrl_pkg::ctrl_write_t swWrite,
  input wire timer_ctrl_pkg::unit_write_t unitWriteReq,
  input wire logic pinAIsOutput,
  input wire logic hwToggle,
  input wire logic pinAIn,
  output logic timerUnitEnable,
  output logic pinOutputLevel,
  output logic counterClockEnable,
  output timer_ctrl_pkg::unit_write_t unitWriteGated,
  output logic pinAOut,
  output logic pinAOe,
  output logic pinAEdge
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic rstMeta;
  logic rstn;

  // Async assert, release through two flops so no flop sees a late edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'h0;
      rstn <= 1'h0;
    end else begin
      rstMeta <= 1'h1;
      rstn <= rstMeta;
    end
  end

  // --------------------------------------------------------------------
  // Pin A input path
  // --------------------------------------------------------------------
  logic pinASync;
  logic pinAPrev;

  bit_synchronizer pinSync (
    .clk(clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .async(pinAIn),
    .synced(pinASync)
  );

  // --------------------------------------------------------------------
  // Next-state decode
  // --------------------------------------------------------------------
  wire logic next_enable;
  wire logic driveLevel;
  wire logic toggleTaken;
  wire logic next_level;
  wire logic next_oe;
  wire logic next_edge;
  wire timer_ctrl_pkg::unit_write_t next_unitWrite;

  assign next_enable = swWrite.enableWrite ? swWrite.enableData : timerUnitEnable;
  // A toggle only means something while the pin is actually driven
  assign driveLevel = timerUnitEnable && pinAIsOutput;
  assign toggleTaken = hwToggle && driveLevel;
  // Software write takes precedence over a colliding toggle
  assign next_level = swWrite.levelWrite ? swWrite.levelData :
                      toggleTaken ? ~pinOutputLevel : pinOutputLevel;
  // Released to input whenever disabled or configured as input
  assign next_oe = next_enable && pinAIsOutput;
  // Counter-side writes pass only while the unit runs
  assign next_unitWrite = timerUnitEnable ? unitWriteReq : '0;
  // Input edges reach the counters only while they are clocked
  // Gated by both enables so a pulse never outlives a disable
  assign next_edge = timerUnitEnable && next_enable && (pinASync != pinAPrev);

  // --------------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerUnitEnable <= `UNIT_ENABLE_RESET;
      pinOutputLevel <= `OUTPUT_LEVEL_RESET;
    end else if (clkEn) begin
      timerUnitEnable <= next_enable;
      pinOutputLevel <= next_level;
    end
  end

  // --------------------------------------------------------------------
  // Outputs towards the counter unit and the pad
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counterClockEnable <= 1'h0;
      unitWriteGated <= '0;
      pinAOut <= `LEVEL_LOW;
      pinAOe <= 1'h0;
      pinAPrev <= 1'h0;
      pinAEdge <= 1'h0;
    end else if (clkEn) begin
      counterClockEnable <= next_enable;
      unitWriteGated <= next_unitWrite;
      pinAOut <= next_level;
      pinAOe <= next_oe;
      pinAPrev <= pinASync;
      pinAEdge <= next_edge;
    end else begin
      // Strobes must not repeat while frozen
      unitWriteGated <= '0;
      pinAEdge <= 1'h0;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic rstSeen;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSeen <= 1'h0;
    end else begin
      rstSeen <= 1'h1;
    end
  end

  a_level_on_pin: assert property (
    @(posedge clk) disable iff (!rstn)
    pinAOe |-> pinAOut == pinOutputLevel)
    else $error("driven pin level differs from level bit");

  a_hw_toggle_flips: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && hwToggle && timerUnitEnable && pinAIsOutput && !swWrite.levelWrite
    |=> pinOutputLevel != $past(pinOutputLevel))
    else $error("hardware toggle did not flip level bit");

  a_sw_level_wins: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && swWrite.levelWrite |=> pinOutputLevel == $past(swWrite.levelData))
    else $error("software level write lost");

  a_input_no_drive: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && !pinAIsOutput |=> !pinAOe)
    else $error("pin driven while configured as input");

  a_enable_write: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && swWrite.enableWrite
    |=> timerUnitEnable == $past(swWrite.enableData) && pinAOe == ($past(swWrite.enableData)
        && $past(pinAIsOutput)))
    else $error("enable write not taken");

  a_clock_stopped: assert property (
    @(posedge clk) disable iff (!rstn)
    !timerUnitEnable |-> !counterClockEnable && !pinAEdge)
    else $error("counter activity while disabled");

  a_writes_blocked: assert property (
    @(posedge clk) disable iff (!rstn)
    !timerUnitEnable ##1 1'h1 |-> unitWriteGated == '0)
    else $error("counter-side write passed while disabled");

  a_pin_released: assert property (
    @(posedge clk) disable iff (!rstn)
    !timerUnitEnable |-> !pinAOe)
    else $error("pin driven while unit disabled");

  a_reset_values: assert property (
    @(posedge clk) disable iff (!rstn)
    !rstSeen |-> !timerUnitEnable && !pinOutputLevel && !pinAOe)
    else $error("control bits not zero after reset");

  a_frozen_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !clkEn |=> $stable(timerUnitEnable) && $stable(pinOutputLevel) && $stable(pinAOe))
    else $error("state moved with clock enable low");

  a_level_held: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && !swWrite.levelWrite && !hwToggle |=> $stable(pinOutputLevel))
    else $error("level bit moved without write or toggle");

  // A toggle that arrives while the pin is not driven must leave no trace
  a_toggle_ignored: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && hwToggle && !swWrite.levelWrite && !(timerUnitEnable && pinAIsOutput)
    |=> $stable(pinOutputLevel))
    else $error("toggle taken while pin not driven");

  a_enable_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && !swWrite.enableWrite |=> $stable(timerUnitEnable))
    else $error("unit enable moved without a write");

  a_edge_gated: assert property (
    @(posedge clk) disable iff (!rstn)
    pinAEdge |-> timerUnitEnable && $past(timerUnitEnable))
    else $error("input edge passed across a disable");

  a_writes_pass: assert property (
    @(posedge clk) disable iff (!rstn)
    clkEn && timerUnitEnable |=> unitWriteGated == $past(unitWriteReq))
    else $error("counter-side write lost while enabled");

  // Strobes are single-cycle events; a frozen cycle must not replay them
  a_strobes_frozen: assert property (
    @(posedge clk) disable iff (!rstn)
    !clkEn |=> unitWriteGated == '0 && !pinAEdge)
    else $error("strobe raised with clock enable low");

endmodule

`default_nettype wire

// *** verification/timer_ctrl_tb.sv ***
/*
  Self-checking bench for the timer enable and pin A output-level control.
  Assumes the package and design files are compiled first and clk runs at 100 MHz.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module timer_ctrl_tb;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic clkEn = 1'h1;
  timer_ctrl_pkg::ctrl_write_t swWrite = '0;
  timer_ctrl_pkg::unit_write_t unitWriteReq = '0;
  logic pinAIsOutput = 1'h0;
  logic hwToggle = 1'h0;
  logic pinAIn = 1'h0;
  logic timerUnitEnable, pinOutputLevel, counterClockEnable, pinAOut, pinAOe, pinAEdge;
  timer_ctrl_pkg::unit_write_t unitWriteGated;
  logic [4:0] bitSel;
  int fails = 0;
  int nChecks = 0;

  always #5 clk = ~clk;

  timer_ctrl dut (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .swWrite(swWrite),
    .unitWriteReq(unitWriteReq),
    .pinAIsOutput(pinAIsOutput),
    .hwToggle(hwToggle),
    .pinAIn(pinAIn),
    .timerUnitEnable(timerUnitEnable),
    .pinOutputLevel(pinOutputLevel),
    .counterClockEnable(counterClockEnable),
    .unitWriteGated(unitWriteGated),
    .pinAOut(pinAOut),
    .pinAOe(pinAOe),
    .pinAEdge(pinAEdge)
  );

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Inputs always move 1 ns after the edge so sampling never races
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task pulse(input logic enW, input logic enD, input logic lvW, input logic lvD,
             input logic tg);
    swWrite = '{enableWrite: enW, enableData: enD, levelWrite: lvW, levelData: lvD};
    hwToggle = tg;
    tick(1);
    swWrite = '0;
    hwToggle = 1'h0;
  endtask

  task checkCtrl(input logic en, input logic lvl, input logic oe);
    `CHK("timerUnitEnable", en, timerUnitEnable)
    `CHK("counterClockEnable", en, counterClockEnable)
    `CHK("pinOutputLevel", lvl, pinOutputLevel)
    `CHK("pinAOut", lvl, pinAOut)
    `CHK("pinAOe", oe, pinAOe)
  endtask

  task testDone;
    if (fails == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    tick(12);
    resetn = 1'h1;
    tick(3);
    checkCtrl(1'h0, 1'h0, 1'h0);
    `CHK("unitWriteGated", 5'h00, unitWriteGated)
    pinAIsOutput = 1'h1;
    unitWriteReq = 5'h1F;
    pulse(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    unitWriteReq = '0;
    checkCtrl(1'h0, 1'h0, 1'h0);
    `CHK("unitWriteGated", 5'h00, unitWriteGated)
    pinAIn = 1'h1;
    repeat (4) begin
      tick(1);
      `CHK("pinAEdge", 1'h0, pinAEdge)
    end
    // Level stays writable while disabled, but must not reach the pad
    pulse(1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    checkCtrl(1'h0, 1'h1, 1'h0);
    clkEn = 1'h0;
    pulse(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    checkCtrl(1'h0, 1'h1, 1'h0);
    clkEn = 1'h1;
    // Enable written in the same cycle must not let the strobes through
    unitWriteReq = 5'h1F;
    pulse(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    unitWriteReq = '0;
    checkCtrl(1'h1, 1'h0, 1'h1);
    `CHK("unitWriteGated", 5'h00, unitWriteGated)
    for (int i = 0; i < 5; i++) begin
      bitSel = 5'h01 << i;
      unitWriteReq = bitSel;
      tick(1);
      unitWriteReq = '0;
      `CHK("unitWriteGated", bitSel, unitWriteGated)
      tick(1);
      `CHK("unitWriteGated", 5'h00, unitWriteGated)
    end
    pulse(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    checkCtrl(1'h1, 1'h1, 1'h1);
    pulse(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    checkCtrl(1'h1, 1'h0, 1'h1);
    pulse(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    pulse(1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    checkCtrl(1'h1, 1'h1, 1'h1);
    pulse(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    pulse(1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    checkCtrl(1'h1, 1'h0, 1'h1);
    pinAIsOutput = 1'h0;
    pulse(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    checkCtrl(1'h1, 1'h0, 1'h0);
    pinAIsOutput = 1'h1;
    pinAIn = 1'h0;
    tick(2);
    `CHK("pinAEdge", 1'h0, pinAEdge)
    tick(1);
    `CHK("pinAEdge", 1'h1, pinAEdge)
    tick(1);
    `CHK("pinAEdge", 1'h0, pinAEdge)
    pulse(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    checkCtrl(1'h0, 1'h0, 1'h0);
    // Second reset in mid-run, taken with both bits set
    pulse(1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    checkCtrl(1'h1, 1'h1, 1'h1);
    resetn = 1'h0;
    tick(1);
    checkCtrl(1'h0, 1'h0, 1'h0);
    resetn = 1'h1;
    tick(3);
    checkCtrl(1'h0, 1'h0, 1'h0);
    `CHK("unitWriteGated", 5'h00, unitWriteGated)
    testDone;
  end

  // The whole sequence needs well under 200 cycles
  initial begin
    repeat (1000) @(posedge clk);
    fails++;
    testDone;
  end
endmodule

`default_nettype wire
